// file: utbbg_defs.svh
`ifndef UTBBG_DEFS_SVH
`define UTBBG_DEFS_SVH

// register indices on the channel register port
`define UTBBG_ADDR_DIV_LO     3'h0
`define UTBBG_ADDR_DIV_HI     3'h1
`define UTBBG_ADDR_LCR        3'h3
`define UTBBG_ADDR_MCR        3'h4
`define UTBBG_ADDR_LSR        3'h5

// line control fields
`define UTBBG_LCR_WLEN_LSB    0
`define UTBBG_LCR_STOP_BIT    2
`define UTBBG_LCR_PAR_BIT     3
`define UTBBG_LCR_BRK_BIT     6
`define UTBBG_LCR_DLAB_BIT    7

// modem control and line status fields
`define UTBBG_MCR_PRESC_BIT   7
`define UTBBG_LSR_BRK_BIT     4

// reset values
`define UTBBG_LCR_RST         8'h1D
`define UTBBG_MCR_RST         8'h00
`define UTBBG_DIV_RST         16'h0000

// timing figures
`define UTBBG_PRESC_DIV       2'h3
`define UTBBG_TICKS_PER_BIT   8'h10
`define UTBBG_STOP1_TICKS     8'h10
`define UTBBG_STOP15_TICKS    8'h18
`define UTBBG_STOP2_TICKS     8'h20
`define UTBBG_BASE_BITS       4'h6
`define UTBBG_TIMEOUT_CHARS   4

// interrupt identity for stale receive data
`define UTBBG_IDENT_TIMEOUT   6'h0C
`define UTBBG_IDENT_NONE      6'h01
`define UTBBG_PRIO_TIMEOUT    3'h2

`endif

// file: utbbg_pkg.sv
`default_nettype none
package utbbg_pkg;
  typedef logic [15:0] utbbg_div_t;
  typedef logic [7:0]  utbbg_byte_t;
  typedef enum logic [1:0] {
    UTBBG_WL5 = 2'b00,
    UTBBG_WL6 = 2'b01,
    UTBBG_WL7 = 2'b10,
    UTBBG_WL8 = 2'b11
  } utbbg_wlen_t;
endpackage
`default_nettype wire

// file: utbbg_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "utbbg_defs.svh"
module utbbg_baud_gen (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // configuration
  input  wire logic              clock_prescale_select,
  input  wire utbbg_pkg::utbbg_div_t divisor,
  // 16x baud tick
  output logic                   baud_tick
);

  logic [1:0]             pre_cnt_q;
  logic                   pre_tick;
  utbbg_pkg::utbbg_div_t  div_cnt_q;
  logic                   wrap;

  //////////////////////////////////////////////////////////////////////////////
  // prescaler: divide by four or pass through
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_q <= 2'h0;
    end else begin
      pre_cnt_q <= clock_prescale_select ? pre_cnt_q + 2'h1 : 2'h0;
    end
  end

  assign pre_tick = !clock_prescale_select || (pre_cnt_q == `UTBBG_PRESC_DIV);

  //////////////////////////////////////////////////////////////////////////////
  // divisor counter; >= compare so a shrunken divisor cannot strand it
  assign wrap = (div_cnt_q >= divisor - 16'h0001);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_q <= 16'h0000;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (divisor == 16'h0000) begin
        div_cnt_q <= 16'h0000;
      end else if (pre_tick) begin
        div_cnt_q <= wrap ? 16'h0000 : div_cnt_q + 16'h0001;
        baud_tick <= wrap;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_ZERO_DIV_SILENT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (divisor == 16'h0000) [*2] |=> !baud_tick)
    else $error("baud tick with zero divisor");

  AST_DIV_ONE_EVERY: assert property (@(posedge core_clk) disable iff (sys_rst)
    (divisor == 16'h0001 && !clock_prescale_select) [*3] |-> baud_tick)
    else $error("divisor one must tick every cycle");

  AST_DIV_TWO_SPACING: assert property (@(posedge core_clk) disable iff (sys_rst)
    (baud_tick && divisor == 16'h0002 && !clock_prescale_select && $stable(divisor)) |=> !baud_tick)
    else $error("divisor two ticked back to back");

  AST_PRESCALE_GAP: assert property (@(posedge core_clk) disable iff (sys_rst)
    (baud_tick && clock_prescale_select) [*1] ##1 clock_prescale_select [*3] |-> !$past(baud_tick))
    else $error("prescaled tick too close");

endmodule
`default_nettype wire

// file: utbbg_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "utbbg_defs.svh"
module utbbg_top #(
  parameter int FIFO_LVL_W = 7
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // register port
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [2:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata_q,
  // serial lines
  input  wire logic                  rx_line,
  input  wire logic                  tx_serial,
  output logic                       tx_line_q,
  // receive path links
  input  wire logic [FIFO_LVL_W-1:0] rx_fifo_level,
  input  wire logic [FIFO_LVL_W-1:0] rx_trigger_level,
  input  wire logic                  rx_fifo_read,
  input  wire logic                  rx_stop_mid,
  // status and pacing
  output logic                       baud_tick_q,
  output logic                       rx_timeout_q,
  output logic [5:0]                 ident_code_q,
  output logic [2:0]                 ident_prio_q,
  output logic                       break_event_q,
  output logic                       clock_prescale_select_q
);

  //////////////////////////////////////////////////////////////////////////////
  // frame length in 16x ticks; 1.5 stop bits only with five-bit words
  function automatic logic [7:0] char_ticks(input logic [7:0] lcr);
    logic [3:0] nbits;
    logic [7:0] stop;
    nbits = `UTBBG_BASE_BITS + {2'b00, lcr[`UTBBG_LCR_WLEN_LSB +: 2]} + {3'b000, lcr[`UTBBG_LCR_PAR_BIT]};
    if (!lcr[`UTBBG_LCR_STOP_BIT]) begin
      stop = `UTBBG_STOP1_TICKS;
    end else if (utbbg_pkg::utbbg_wlen_t'(lcr[`UTBBG_LCR_WLEN_LSB +: 2]) == utbbg_pkg::UTBBG_WL5) begin
      stop = `UTBBG_STOP15_TICKS;
    end else begin
      stop = `UTBBG_STOP2_TICKS;
    end
    char_ticks = {nbits, 4'h0} + stop;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers
  utbbg_pkg::utbbg_byte_t div_lo_q;
  utbbg_pkg::utbbg_byte_t div_hi_q;
  utbbg_pkg::utbbg_byte_t lcr_q;
  utbbg_pkg::utbbg_div_t  divisor;
  logic                   dlab;
  logic                   brk_seen_q;
  logic                   lsr_rd;
  logic                   gen_tick;

  assign dlab    = lcr_q[`UTBBG_LCR_DLAB_BIT];
  assign divisor = {div_hi_q, div_lo_q};
  assign lsr_rd  = reg_rd && reg_addr == `UTBBG_ADDR_LSR;

  // divisor bytes are written only with the latch access bit set
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_lo_q <= 8'(`UTBBG_DIV_RST);
      div_hi_q <= 8'(`UTBBG_DIV_RST >> 8);
    end else if (reg_wr && dlab) begin
      if (reg_addr == `UTBBG_ADDR_DIV_LO) begin
        div_lo_q <= reg_wdata;
      end
      if (reg_addr == `UTBBG_ADDR_DIV_HI) begin
        div_hi_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lcr_q <= `UTBBG_LCR_RST;
    end else if (reg_wr && reg_addr == `UTBBG_ADDR_LCR) begin
      lcr_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_prescale_select_q <= 1'b0;
    end else if (reg_wr && reg_addr == `UTBBG_ADDR_MCR) begin
      clock_prescale_select_q <= reg_wdata[`UTBBG_MCR_PRESC_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `UTBBG_ADDR_DIV_LO: reg_rdata_q <= dlab ? div_lo_q : 8'h00;
        `UTBBG_ADDR_DIV_HI: reg_rdata_q <= dlab ? div_hi_q : 8'h00;
        `UTBBG_ADDR_LCR: reg_rdata_q <= lcr_q;
        `UTBBG_ADDR_MCR: reg_rdata_q <= {clock_prescale_select_q, 7'h00};
        `UTBBG_ADDR_LSR: reg_rdata_q <= {3'h0, brk_seen_q, 4'h0};
        default:         reg_rdata_q <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // baud generator; its tick paces transmitter and receiver alike
  utbbg_baud_gen i_utbbg_baud_gen (
    .core_clk              (core_clk),
    .sys_rst               (sys_rst),
    .clock_prescale_select (clock_prescale_select_q),
    .divisor               (divisor),
    .baud_tick             (gen_tick)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baud_tick_q <= 1'b0;
    end else begin
      baud_tick_q <= gen_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive time-out
  logic [7:0] frame_ticks;
  logic [9:0] to_limit;
  logic [9:0] to_cnt_q;
  logic       to_armed;
  logic       to_restart;
  logic       to_hit;

  assign frame_ticks = char_ticks(lcr_q);
  assign to_limit    = 10'(frame_ticks * `UTBBG_TIMEOUT_CHARS);
  assign to_armed    = (rx_fifo_level != '0) && (rx_fifo_level < rx_trigger_level);
  assign to_restart  = rx_stop_mid || rx_fifo_read;
  assign to_hit      = (to_cnt_q == to_limit - 10'h001) && gen_tick;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      to_cnt_q <= 10'h000;
    end else if (to_restart || !to_armed) begin
      to_cnt_q <= 10'h000;
    end else if (gen_tick && to_cnt_q != to_limit) begin
      to_cnt_q <= to_cnt_q + 10'h001;
    end
  end

  // a hit in the same cycle as a restart is dropped: the restart means fresh data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_timeout_q <= 1'b0;
    end else if (to_restart || !to_armed) begin
      rx_timeout_q <= 1'b0;
    end else if (to_hit) begin
      rx_timeout_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ident_code_q <= `UTBBG_IDENT_NONE;
      ident_prio_q <= 3'h0;
    end else begin
      ident_code_q <= rx_timeout_q ? `UTBBG_IDENT_TIMEOUT : `UTBBG_IDENT_NONE;
      ident_prio_q <= rx_timeout_q ? `UTBBG_PRIO_TIMEOUT : 3'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // break detection: one event per low stretch
  logic [8:0] brk_cnt_q;
  logic       brk_fire;

  assign brk_fire = !rx_line && gen_tick && (brk_cnt_q == {1'b0, frame_ticks});

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      brk_cnt_q <= 9'h000;
    end else if (rx_line) begin
      brk_cnt_q <= 9'h000;
    end else if (gen_tick && brk_cnt_q <= {1'b0, frame_ticks}) begin
      brk_cnt_q <= brk_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      break_event_q <= 1'b0;
    end else begin
      break_event_q <= brk_fire;
    end
  end

  // sticky status; a new break beats the clearing read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      brk_seen_q <= 1'b0;
    end else if (brk_fire) begin
      brk_seen_q <= 1'b1;
    end else if (lsr_rd) begin
      brk_seen_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit line: break holds it low regardless of the shifter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_line_q <= 1'b1;
    end else begin
      tx_line_q <= lcr_q[`UTBBG_LCR_BRK_BIT] ? 1'b0 : tx_serial;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_TX_BREAK_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    lcr_q[`UTBBG_LCR_BRK_BIT] |=> !tx_line_q)
    else $error("tx not low during break");

  AST_TX_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!lcr_q[`UTBBG_LCR_BRK_BIT] && tx_serial) |=> tx_line_q)
    else $error("tx held low without break");

  AST_TIMEOUT_RESTART: assert property (@(posedge core_clk) disable iff (sys_rst)
    to_restart |=> (to_cnt_q == 10'h000) && !rx_timeout_q)
    else $error("time-out not restarted");

  AST_TIMEOUT_FIRE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to_armed && !to_restart && gen_tick && to_cnt_q == to_limit - 10'h001) |=> rx_timeout_q)
    else $error("time-out missed at four character times");

  AST_TIMEOUT_CAUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(rx_timeout_q) |-> $past(to_cnt_q) == to_limit - 10'h001 && $past(to_armed))
    else $error("time-out raised early");

  AST_IDENT_TIMEOUT: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_timeout_q |=> ident_code_q == 6'h0C && ident_prio_q == 3'h2)
    else $error("wrong identity for time-out");

  AST_BREAK_CAUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    break_event_q |-> !$past(rx_line) && $past(brk_cnt_q) == {1'b0, $past(frame_ticks)})
    else $error("break flagged before a full frame low");

  AST_BREAK_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
    break_event_q |-> brk_seen_q)
    else $error("break status not set");

  AST_DIV_JOIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && dlab && reg_addr == 3'h1) |=> div_hi_q == $past(reg_wdata))
    else $error("divisor high byte not stored");

  AST_SHARED_TICK: assert property (@(posedge core_clk) disable iff (sys_rst)
    gen_tick |=> baud_tick_q)
    else $error("generator tick not forwarded");

  AST_IDENT_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !rx_timeout_q |=> ident_code_q == 6'h01 && ident_prio_q == 3'h0)
    else $error("identity shows time-out without one");

  AST_TIMEOUT_DISARM: assert property (@(posedge core_clk) disable iff (sys_rst)
    !to_armed |=> !rx_timeout_q)
    else $error("time-out held while not armed");

  AST_BREAK_ONCE: assert property (@(posedge core_clk) disable iff (sys_rst)
    break_event_q |=> !break_event_q)
    else $error("break event longer than one cycle");

  AST_BREAK_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lsr_rd && !brk_fire) |=> !brk_seen_q)
    else $error("break status survived its read");

  AST_TX_FOLLOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!lcr_q[`UTBBG_LCR_BRK_BIT] && !tx_serial) |=> !tx_line_q)
    else $error("tx line does not follow the shifter");

  AST_DIV_LOW_JOIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && dlab && reg_addr == 3'h0) |=> div_lo_q == $past(reg_wdata))
    else $error("divisor low byte not stored");

endmodule
`default_nettype wire

// file: utbbg_remote.sv
`timescale 1ns/10ps
`default_nettype none
module utbbg_remote (
  // clock
  input  wire logic core_clk,
  // serial lines
  input  wire logic tx_line,
  output var logic  rx_line
);
  // sticky: transmit line seen low at least once
  logic tx_low_seen = 1'b0;

  // line rests at mark between frames
  initial begin
    rx_line = 1'b1;
  end

  always @(posedge core_clk) begin
    if (tx_line === 1'b0) begin
      tx_low_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a low stretch longer than a frame is what a break looks like from here
  task hold_low(input int k);
    @(posedge core_clk);
    #1;
    rx_line = 1'b0;
    repeat (k) @(posedge core_clk);
    #1;
    rx_line = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: test_uart_timeout_break_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "utbbg_defs.svh"
module test_uart_timeout_break_baud_gen;
  typedef struct packed {
    logic       w;
    logic [2:0] a;
    logic [7:0] d;
  } utbbg_row_t;

  logic       core_clk, sys_rst, reg_wr, reg_rd, tx_serial, rx_fifo_read, rx_stop_mid;
  logic       rx_line, tx_line_q, baud_tick_q, rx_timeout_q, break_event_q, presc_q;
  logic [2:0] reg_addr, ident_prio_q;
  logic [7:0] reg_wdata, reg_rdata_q;
  logic [5:0] ident_code_q;
  logic [6:0] rx_fifo_level, rx_trigger_level;
  int         checks, fail_count, brk_cnt, n, k;
  utbbg_row_t rows [12] = '{
    '{1'b0, 3'h3, `UTBBG_LCR_RST}, '{1'b0, 3'h4, 8'h00}, '{1'b0, 3'h0, 8'h00},
    '{1'b1, 3'h3, 8'h83}, '{1'b1, 3'h0, 8'hA5}, '{1'b0, 3'h0, 8'hA5},
    '{1'b1, 3'h1, 8'h5A}, '{1'b0, 3'h1, 8'h5A}, '{1'b0, 3'h2, 8'h00},
    '{1'b1, 3'h4, 8'h80}, '{1'b0, 3'h4, 8'h80}, '{1'b1, 3'h4, 8'h00}};

  utbbg_top #(.FIFO_LVL_W(7)) i_utbbg_top (
    .core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
    .rx_line, .tx_serial, .tx_line_q, .rx_fifo_level, .rx_trigger_level, .rx_fifo_read,
    .rx_stop_mid, .baud_tick_q, .rx_timeout_q, .ident_code_q, .ident_prio_q, .break_event_q,
    .clock_prescale_select_q(presc_q));

  utbbg_remote i_utbbg_remote (.core_clk, .tx_line(tx_line_q), .rx_line);

  ////////////////////////////////////////////////////////////////////////////////
  task results;
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  // extra idle cycle so back to back strobes never merge
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task rd(input logic [2:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask

  task cnt(input int c);
    n = 0;
    repeat (c) begin
      cyc(1);
      n += int'(baud_tick_q === 1'b1);
    end
  endtask

  always @(posedge core_clk) begin
    if (break_event_q === 1'b1) begin
      brk_cnt <= brk_cnt + 1;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, reg_wr, reg_rd, tx_serial, rx_fifo_read, rx_stop_mid} = 6'b100100;
    {reg_addr, reg_wdata, rx_fifo_level} = '0;
    rx_trigger_level = 7'h04;
    {checks, fail_count} = '0;
    cyc(2);
    sys_rst = 1'b0;
    chk(8'(tx_line_q), 8'h01);
    chk(8'(presc_q), 8'h00);
    chk(8'(ident_code_q), 8'(`UTBBG_IDENT_NONE));
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a);
        chk(reg_rdata_q, rows[i].d);
      end
    end
    // LCR still holds 8'h83 with the latch access bit set, so divisor writes are allowed
    wr(3'h0, 8'h03);
    wr(3'h1, 8'h00);
    cyc(10);
    cnt(30);
    chk(8'(n), 8'h0A);
    wr(3'h4, 8'h80);
    chk(8'(presc_q), 8'h01);
    cyc(20);
    cnt(120);
    chk(8'(n), 8'h0A);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    cyc(300);
    cnt(512);
    chk(8'(n), 8'h02);
    wr(3'h1, 8'h00);
    cyc(10);
    cnt(50);
    chk(8'(n), 8'h00);
    wr(3'h0, 8'h02);
    cyc(4);
    cnt(20);
    chk(8'(n), 8'h0A);
    wr(3'h0, 8'h01);
    cyc(2);
    cnt(16);
    chk(8'(n), 8'h10);
    // transmit break forced and released
    chk(8'(i_utbbg_remote.tx_low_seen), 8'h00);
    wr(3'h3, 8'hC3);
    cyc(1);
    chk(8'(tx_line_q), 8'h00);
    cyc(50);
    chk(8'(tx_line_q), 8'h00);
    wr(3'h3, 8'h83);
    cyc(1);
    chk(8'(tx_line_q), 8'h01);
    chk(8'(i_utbbg_remote.tx_low_seen), 8'h01);
    tx_serial = 1'b0;
    cyc(1);
    chk(8'(tx_line_q), 8'h00);
    tx_serial = 1'b1;
    cyc(1);
    chk(8'(tx_line_q), 8'h01);
    // 8N1 frame is 160 ticks, divisor one gives a tick a cycle
    k = brk_cnt;
    fork
      i_utbbg_remote.hold_low(300);
      begin
        cyc(150);
        chk(8'(brk_cnt - k), 8'h00);
      end
    join
    cyc(5);
    chk(8'(brk_cnt - k), 8'h01);
    rd(3'h5);
    chk(reg_rdata_q & 8'h10, 8'h10);
    rd(3'h5);
    chk(reg_rdata_q & 8'h10, 8'h00);
    // time-out after four frames of 160 ticks
    rx_fifo_level = 7'h01;
    rx_fifo_read = 1'b1;
    cyc(1);
    rx_fifo_read = 1'b0;
    cyc(630);
    chk(8'(rx_timeout_q), 8'h00);
    for (k = 0; k < 40 && rx_timeout_q !== 1'b1; k++) begin
      cyc(1);
    end
    chk(8'(rx_timeout_q), 8'h01);
    cyc(2);
    chk(8'(ident_code_q), 8'(`UTBBG_IDENT_TIMEOUT));
    chk(8'(ident_prio_q), 8'(`UTBBG_PRIO_TIMEOUT));
    rx_fifo_read = 1'b1;
    cyc(1);
    rx_fifo_read = 1'b0;
    cyc(2);
    chk(8'(rx_timeout_q), 8'h00);
    cyc(400);
    rx_stop_mid = 1'b1;
    cyc(1);
    rx_stop_mid = 1'b0;
    cyc(400);
    chk(8'(rx_timeout_q), 8'h00);
    rx_fifo_level = 7'h04;
    cyc(700);
    chk(8'(rx_timeout_q), 8'h00);
    // mid-run reset brings back the defaults
    wr(3'h4, 8'h80);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    chk(8'(presc_q), 8'h00);
    chk(8'(tx_line_q), 8'h01);
    chk(8'(rx_timeout_q), 8'h00);
    chk(8'(ident_code_q), 8'(`UTBBG_IDENT_NONE));
    cnt(40);
    chk(8'(n), 8'h00);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    cyc(2);
    cnt(16);
    chk(8'(n), 8'h10);
    results();
  end
endmodule
`default_nettype wire
